// File: dv/tb_tec_timer.sv
// Directed bench for the timer/event counter
`timescale 1ns/1ps
module tb_tec_timer
  import tec_pkg::*;
;
  logic core_clk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o;
  logic src_div4, sleep_mode, timer_pin, timer_irq, wake_req, go, woke, e;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0] width, q, c;
  int miscompares, cmp_count, cycles;
  tec_timer tec_timer_i(.core_clk, .rst, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .timer_pin, .src_div4, .sleep_mode, .timer_irq, .wake_req);
  tec_pin_src tec_pin_src_i(.core_clk, .go, .width, .pin(timer_pin));
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Wake capture and hang limit
  always @(posedge core_clk) begin
    cycles++;
    if (wake_req === 1'b1) woke <= 1'b1;
    if (cycles == 20000) begin
      miscompares++;
      conclude;
    end
  end
  task chk(input string n, input logic [7:0] s, input logic [7:0] x);
    cmp_count++;
    if (s !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  // One classic Wishbone cycle; read byte in q, error in e
  task bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= {24'h000000, d};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    q = wb_dat_o[7:0];
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task pulse(input logic [7:0] w);
    go <= 1'b1;
    width <= w;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (w + 12) @(posedge core_clk);
  endtask
  task t_reset;
    bus(4'h0, 1'b0, 8'h00); chk("ctl", q, TEC_CTL_RESET);
    bus(4'hC, 1'b0, 8'h00); chk("int", q, TEC_INT_RESET);
    bus(4'h8, 1'b0, 8'h00); chk("cnt", q, TEC_COUNT_RESET);
    bus(4'h0, 1'b1, 8'hFF);
    bus(4'h0, 1'b0, 8'h00); chk("mask", q, TEC_CTL_MASK);
    bus(4'h0, 1'b1, 8'h00);
    bus(4'h2, 1'b0, 8'h00); chk("err", {7'h00, e}, 8'h01);
  endtask
  task t_timer;
    bus(4'h4, 1'b1, 8'h10);
    bus(4'h8, 1'b0, 8'h00); chk("load", q, 8'h10);
    src_div4 <= 1'b1;
    bus(4'h0, 1'b1, 8'h91);
    repeat (400) @(posedge core_clk);
    bus(4'h0, 1'b1, 8'h81);
    bus(4'h8, 1'b0, 8'h00);
    c = q;
    chk("rate", {7'h00, c inside {[8'h40:8'h44]}}, 8'h01);
    repeat (40) @(posedge core_clk);
    bus(4'h8, 1'b0, 8'h00); chk("hold", q, c);
  endtask
  task t_ovf;
    src_div4 <= 1'b0;
    bus(4'h4, 1'b1, 8'hF0);
    bus(4'h0, 1'b1, 8'h90);
    repeat (30) @(posedge core_clk);
    bus(4'h8, 1'b0, 8'h00); chk("reload", {7'h00, q >= 8'hF0}, 8'h01);
    bus(4'h0, 1'b1, 8'h80);
    bus(4'hC, 1'b0, 8'h00); chk("flag", q, 8'h20);
    chk("irq off", {7'h00, timer_irq}, 8'h00);
    bus(4'hC, 1'b1, 8'h24);
    bus(4'hC, 1'b0, 8'h00); chk("irq on", {7'h00, timer_irq}, 8'h01);
    bus(4'hC, 1'b1, 8'h00);
    bus(4'hC, 1'b0, 8'h00); chk("irq clr", {7'h00, timer_irq}, 8'h00);
  endtask
  task t_event;
    bus(4'h4, 1'b1, 8'hFB);
    sleep_mode <= 1'b1;
    bus(4'h0, 1'b1, 8'h57);
    repeat (5) pulse(8'h06);
    bus(4'h8, 1'b0, 8'h00); chk("rise", q, 8'hFB);
    chk("wake", {7'h00, woke}, 8'h01);
    bus(4'h0, 1'b1, 8'h5F);
    repeat (2) pulse(8'h06);
    bus(4'h8, 1'b0, 8'h00); chk("fall", q, 8'hFD);
    bus(4'h0, 1'b0, 8'h00); chk("keep", q, 8'h5F);
    sleep_mode <= 1'b0;
    bus(4'h0, 1'b1, 8'h00);
  endtask
  task t_pulse;
    bus(4'h4, 1'b1, 8'h00);
    bus(4'h0, 1'b1, 8'hD0);
    repeat (20) @(posedge core_clk);
    bus(4'h8, 1'b0, 8'h00); chk("armed", q, 8'h00);
    pulse(8'h28);
    bus(4'h8, 1'b0, 8'h00);
    c = q;
    chk("width", {7'h00, c inside {[8'h26:8'h2A]}}, 8'h01);
    bus(4'h0, 1'b0, 8'h00); chk("stop", q, 8'hC0);
    pulse(8'h10);
    bus(4'h8, 1'b0, 8'h00); chk("once", q, c);
    bus(4'h4, 1'b1, 8'h00);
    bus(4'h0, 1'b1, 8'hD8);
    pulse(8'h0A);
    pulse(8'h0A);
    bus(4'h8, 1'b0, 8'h00); chk("high", {7'h00, q inside {[8'h0B:8'h0F]}}, 8'h01);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    {wb_we_i, wb_cyc_i, wb_stb_i, src_div4, sleep_mode, go, woke} = 7'h00;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h00000000;
    width = 8'h00;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_timer;
    t_ovf;
    t_event;
    t_pulse;
    conclude;
  end
endmodule

// File: dv/tec_pin_src.sv
// External pulse source driving the timer pin
`timescale 1ns/1ps
module tec_pin_src
(
  input wire logic core_clk,
  input wire logic go,
  input wire logic [7:0] width,
  output logic pin
);
  logic [7:0] left_reg = 8'h00;
  // Counts down the low time of one pulse
  always_ff @(posedge core_clk) begin
    if (go) begin
      left_reg <= width;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  // Pin rests high as if pulled up, the block only ever reads it
  assign pin = (left_reg == 8'h00);
endmodule

// File: dv/tec_timer_chk.sv
// Bus, reset and wake-up checks for the timer/event counter
`timescale 1ns/1ps
module tec_timer_chk
  import tec_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic sleep_mode,
  input wire logic timer_irq,
  input wire logic wake_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // An unanswered request and whether it hits a mapped word
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic hit = wb_adr_i[1:0] == 2'h0;
  bus_answer_a: assert property (req |=> wb_ack_o || wb_err_o) else $error("request unanswered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  err_pulse_a: assert property (wb_err_o |=> !wb_err_o) else $error("err too long");
  err_hit_a: assert property (req && hit |=> !wb_err_o) else $error("mapped word refused");
  err_miss_a: assert property (req && !hit |=> wb_err_o) else $error("unmapped word taken");
  dat_high_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper data set");
  ctl_bit5_a: assert property (req && !wb_we_i && wb_adr_i == TEC_OFF_CONTROL |=> !wb_dat_o[5])
    else $error("bit 5 reads one");
  wake_sleep_a: assert property (wake_req |-> sleep_mode) else $error("wake while awake");
  irq_reset_a: assert property ($fell(rst) |-> !timer_irq) else $error("irq after reset");
endmodule
bind tec_timer tec_timer_chk tec_timer_chk_i(.core_clk, .rst, .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .wb_err_o, .sleep_mode, .timer_irq, .wake_req);

// File: logic/tec_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module tec_pin_sync
  import tec_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } tec_sync_t;
  tec_sync_t st_reg;
  tec_sync_t st_next;

  // Stage one feeds only stage two; a change counts when stages two and three agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
    end
  end

  // Reset to high, the idle level of a pulled-up pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.lvl;
  assign rise = (st_next.lvl && !st_reg.lvl);
  assign fall = (!st_next.lvl && st_reg.lvl);
endmodule

// File: logic/tec_pkg.sv
// Package with register map, field positions and reset values of the timer/event counter
package tec_pkg;
  // Register word offsets (byte addresses)
  localparam logic [3:0] TEC_OFF_CONTROL = 4'h0;
  localparam logic [3:0] TEC_OFF_PRELOAD = 4'h4;
  localparam logic [3:0] TEC_OFF_COUNT = 4'h8;
  localparam logic [3:0] TEC_OFF_INTCTL = 4'hC;
  // Control field positions
  localparam int TEC_CTL_MODE_HI = 7;
  localparam int TEC_CTL_MODE_LO = 6;
  localparam int TEC_CTL_EN = 4;
  localparam int TEC_CTL_EDGE = 3;
  localparam int TEC_CTL_PSC_HI = 2;
  // Implemented control bits and reset value
  localparam logic [7:0] TEC_CTL_MASK = 8'hDF;
  localparam logic [7:0] TEC_CTL_RESET = 8'h08;
  // Interrupt control fields
  localparam int TEC_INT_FLAG = 5;
  localparam int TEC_INT_EN = 2;
  localparam logic [7:0] TEC_INT_MASK = 8'h24;
  localparam logic [7:0] TEC_INT_RESET = 8'h00;
  localparam logic [7:0] TEC_PRELOAD_RESET = 8'h00;
  localparam logic [7:0] TEC_COUNT_RESET = 8'h00;
  localparam logic [7:0] TEC_COUNT_FULL = 8'hFF;
  // Source clock pre-divider for the instruction-clock option
  localparam int TEC_SYS_DIV4 = 4;
  // Operating modes
  typedef enum logic [1:0] {
    TEC_MODE_NONE = 2'b00,
    TEC_MODE_EVENT = 2'b01,
    TEC_MODE_TIMER = 2'b10,
    TEC_MODE_PULSE = 2'b11
  } tec_mode_t;
endpackage

// File: logic/tec_prescaler.sv
// Free-running divider giving a one-cycle tick per falling edge of the prescaled clock
`timescale 1ns/1ps
module tec_prescaler
  import tec_pkg::*;
#(
  parameter int DIV_W = 10
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic src_div4,
  input wire logic [2:0] psc_code,
  output logic tick
);
  // Elaboration check: the widest tap is the /4 source with the /128 code
  if (DIV_W < 10) begin : g_div_w_check
    $error("tec_prescaler: DIV_W too small for /4 and /128");
  end

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } tec_psc_t;
  tec_psc_t st_reg;
  tec_psc_t st_next;
  logic [3:0] tap;

  // Pick the bit whose high-to-low step is the prescaled tick
  always_comb begin
    st_next = st_reg;
    st_next.cnt = st_reg.cnt + 1'b1;
    tap = {1'b0, psc_code} + (src_div4 ? 4'h2 : 4'h0);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Code 000 with the plain system clock ticks every cycle
  assign tick = (tap == 4'h0) ? 1'b1 : (st_reg.cnt[tap - 4'h1] && !st_next.cnt[tap - 4'h1]);
endmodule

// File: logic/tec_timer.sv
// 8-bit timer/event counter with Wishbone register access
// What this block does
// - Mode bits 7:6 select none/event/timer/pulse
// - Bit 4 runs counter when set
// - Bits 2:0 divide internal clock by 1..128
// - Pin-clocked counting ignores the prescaler
// - Event mode counts rising or falling edge
// - Pulse mode edge pair chosen by edge bit
// - Pulse mode enable only arms counting
// - Pulse end clears enable, keeps count
// - After pulse end ignore pin until re-enabled
// - Timer and event modes never self-clear enable
// - Timer mode counts prescaled clock falling edges
// - Overflow raises request flag and reloads preload
// - Event counting continues in sleep, wakes
// - Overflow wakes; interrupt needs enable bit
// - Timer source is system clock or divided four
// - Pulse mode driven by transitions only
// - Control resets 08h, bit 5 reads zero
// - Preload loads counter at once when stopped
// - Overflow sets request flag regardless of enable
`timescale 1ns/1ps
module tec_timer
  import tec_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic timer_pin,
  input wire logic src_div4,
  input wire logic sleep_mode,
  output logic timer_irq,
  output logic wake_req
);
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] preload;
    logic [7:0] count;
    logic [7:0] intctl;
    logic pulse_active;
    logic ack;
    logic err;
    logic [7:0] rdata;
    logic wake;
  } tec_state_t;
  tec_state_t st_reg;
  tec_state_t st_next;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic psc_tick;

  // Register index decode used for both reads and writes
  function automatic logic [2:0] reg_hit(input logic [3:0] adr);
    if (adr == TEC_OFF_CONTROL) begin
      reg_hit = 3'h1;
    end else if (adr == TEC_OFF_PRELOAD) begin
      reg_hit = 3'h2;
    end else if (adr == TEC_OFF_COUNT) begin
      reg_hit = 3'h3;
    end else if (adr == TEC_OFF_INTCTL) begin
      reg_hit = 3'h4;
    end else begin
      reg_hit = 3'h0;
    end
  endfunction

  // Timer pin synchroniser
  tec_pin_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(timer_pin),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Internal clock divider
  tec_prescaler #(
    .DIV_W(10)
  ) u_psc (
    .core_clk(core_clk),
    .rst(rst),
    .src_div4(src_div4),
    .psc_code(st_reg.ctl[TEC_CTL_PSC_HI:0]),
    .tick(psc_tick)
  );

  tec_mode_t mode;
  logic enabled;
  logic edge_sel;
  logic start_edge;
  logic stop_edge;
  logic count_step;
  logic overflow;
  logic wr_stb;
  logic rd_stb;
  logic [2:0] hit;
  logic [7:0] wbyte;

  always_comb begin
    mode = tec_mode_t'(st_reg.ctl[TEC_CTL_MODE_HI:TEC_CTL_MODE_LO]);
    enabled = st_reg.ctl[TEC_CTL_EN];
    edge_sel = st_reg.ctl[TEC_CTL_EDGE];
    hit = reg_hit(wb_adr_i);
    wbyte = wb_dat_i[7:0];
    wr_stb = wb_cyc_i && wb_stb_i && !st_reg.ack && !st_reg.err && wb_we_i && wb_sel_i[0];
    rd_stb = wb_cyc_i && wb_stb_i && !st_reg.ack && !st_reg.err && !wb_we_i;
    // Pulse mode: edge 0 starts on fall, stops on rise; edge 1 the reverse
    start_edge = edge_sel ? pin_rise : pin_fall;
    stop_edge = edge_sel ? pin_fall : pin_rise;
    count_step = 1'b0;
    if (enabled) begin
      case (mode)
        TEC_MODE_EVENT: count_step = edge_sel ? pin_fall : pin_rise;
        TEC_MODE_TIMER: count_step = psc_tick;
        TEC_MODE_PULSE: count_step = st_reg.pulse_active && psc_tick && !stop_edge;
        default: count_step = 1'b0;
      endcase
    end
    overflow = count_step && (st_reg.count == TEC_COUNT_FULL);
  end

  // Counter, control and bus state
  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.err = 1'b0;
    st_next.wake = 1'b0;
    // Counting; overflow reloads from preload
    if (overflow) begin
      st_next.count = st_reg.preload;
      st_next.wake = 1'b1;
    end else if (count_step) begin
      st_next.count = st_reg.count + 8'h01;
    end
    // Pulse measurement arm, start and stop
    if (mode == TEC_MODE_PULSE && enabled) begin
      if (!st_reg.pulse_active && start_edge) begin
        st_next.pulse_active = 1'b1;
      end else if (st_reg.pulse_active && stop_edge) begin
        st_next.pulse_active = 1'b0;
        st_next.ctl[TEC_CTL_EN] = 1'b0;
      end
    end else begin
      st_next.pulse_active = 1'b0;
    end
    // Register writes
    if (wr_stb) begin
      if (hit == 3'h1) begin
        st_next.ctl = wbyte & TEC_CTL_MASK;
        if (!wbyte[TEC_CTL_EN] || wbyte[TEC_CTL_MODE_HI:TEC_CTL_MODE_LO] != TEC_MODE_PULSE) begin
          st_next.pulse_active = 1'b0;
        end
      end else if (hit == 3'h2) begin
        st_next.preload = wbyte;
        if (!enabled) begin
          st_next.count = wbyte;
        end
      end else if (hit == 3'h4) begin
        st_next.intctl = wbyte & TEC_INT_MASK;
      end
    end
    // Overflow sets the request flag; set wins over a clearing write
    if (overflow) begin
      st_next.intctl[TEC_INT_FLAG] = 1'b1;
    end
    // Bus answer
    if (wr_stb || rd_stb) begin
      if (hit == 3'h0) begin
        st_next.err = 1'b1;
      end else begin
        st_next.ack = 1'b1;
      end
    end
    if (rd_stb) begin
      if (hit == 3'h1) begin
        st_next.rdata = st_reg.ctl & TEC_CTL_MASK;
      end else if (hit == 3'h2) begin
        st_next.rdata = st_reg.preload;
      end else if (hit == 3'h3) begin
        st_next.rdata = st_reg.count;
      end else if (hit == 3'h4) begin
        st_next.rdata = st_reg.intctl;
      end else begin
        st_next.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= '{ctl: TEC_CTL_RESET, preload: TEC_PRELOAD_RESET, count: TEC_COUNT_RESET,
                  intctl: TEC_INT_RESET, pulse_active: 1'b0, ack: 1'b0, err: 1'b0,
                  rdata: 8'h00, wake: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign wb_ack_o = st_reg.ack;
  assign wb_err_o = st_reg.err;
  assign wb_dat_o = {24'h000000, st_reg.rdata};
  assign timer_irq = st_reg.intctl[TEC_INT_FLAG] && st_reg.intctl[TEC_INT_EN];
  assign wake_req = st_reg.wake && sleep_mode;
endmodule
